//--- core/phy_power_mdix.sv
`timescale 1ns/1ps
// Functional notes
// - the management data pin is shared by up to 32 devices, each driving only when addressed.
// - the signal-detect monitor stays enabled in every power state, reduced power included.
// - a disconnected cable puts the device into reduced power in autoneg and forced mode alike.
// - in reduced power the transmitter keeps sending fast link pulses at minimal power.
// - a valid link pulse or MLT-3 signal wakes the device from reduced power to normal operation.
// - clearing bit 4 of register 16 disables automatic entry into reduced power.
// - full power-down follows bit 11 of register 0 or a high power-down pin.
// - full power-down stops transmit, receive and data interface but keeps management alive.
// - automatic crossover timing comes from a sixteen-bit linear feedback shift register.
// - each crossover switching interval lies between 200 ms and 420 ms.
// - outside full power-down, crossover keeps alternating until a received signal is seen and then holds.
// - the chosen crossover polarity is reported in bit 7 of register 20.
// - bit 4 of register 20, reset to zero, disables automatic crossover when set.
// - with auto crossover disabled, bit 5 of register 20 picks straight (0) or crossover (1).
module phy_power_mdix
	import phy_pwr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic power_down_pin,
	input wire logic xover_strap,
	input wire mode_ctl_t mode_ctl,
	input wire media_sense_t media,
	input wire logic mdio_addressed,
	input wire logic mdio_out_bit,
	input wire logic mdio_out_valid,
	output logic mdio_o,
	output logic mdio_oe,
	output logic signal_detect_en,
	output logic tx_enable,
	output logic rx_enable,
	output logic mii_enable,
	output logic mgmt_enable,
	output logic tx_flp_low_power,
	output logic reduced_power,
	output logic full_power_down,
	output logic mdix_select,
	output logic xover_status
);
	power_state_t state;
	power_state_t next_state;
	logic [15:0] crossover_pseudo_random_timer;
	logic [31:0] interval_count;
	logic [31:0] interval_target;
	logic signal_seen;
	logic auto_xover;
	logic pd_req;

	localparam logic [31:0] span_cycles = 32'(xover_max_cycles - xover_min_cycles);

	function automatic logic [31:0] pick_interval(input logic [15:0] r);
		// scale the 16-bit value across the allowed span
		pick_interval = 32'(xover_min_cycles) + 32'((64'(r) * 64'(span_cycles)) >> 16);
	endfunction

	assign signal_seen = media.fast_link_pulse | media.normal_link_pulse | media.mlt3_signal;
	assign pd_req = mode_ctl.power_down | power_down_pin;
	assign auto_xover = ~xover_strap & ~mode_ctl.xover_disable;

	always_comb begin
		next_state = state;
		case (state)
			pm_normal: begin
				if (pd_req) begin
					next_state = pm_down;
				end else if (!media.cable_present && mode_ctl.auto_reduced_en) begin
					next_state = pm_reduced;
				end
			end
			pm_reduced: begin
				if (pd_req) begin
					next_state = pm_down;
				end else if (signal_seen || !mode_ctl.auto_reduced_en) begin
					next_state = pm_normal;
				end
			end
			pm_down: begin
				if (!pd_req) begin
					next_state = pm_normal;
				end
			end
			default: next_state = pm_normal;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= pm_normal;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			signal_detect_en <= 1'b1;
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			mii_enable <= 1'b0;
			mgmt_enable <= 1'b1;
			tx_flp_low_power <= 1'b0;
			reduced_power <= 1'b0;
			full_power_down <= 1'b0;
		end else begin
			signal_detect_en <= 1'b1;
			mgmt_enable <= 1'b1;
			tx_enable <= (next_state != pm_down);
			rx_enable <= (next_state == pm_normal);
			mii_enable <= (next_state == pm_normal);
			tx_flp_low_power <= (next_state == pm_reduced);
			reduced_power <= (next_state == pm_reduced);
			full_power_down <= (next_state == pm_down);
		end
	end

	// management data pin: driven only while this device is addressed
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mdio_o <= 1'b0;
			mdio_oe <= 1'b0;
		end else begin
			mdio_oe <= mdio_addressed & mdio_out_valid;
			mdio_o <= mdio_out_bit;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			crossover_pseudo_random_timer <= crossover_pseudo_random_timer_seed;
		end else begin
			// galois step every cycle so the interval choice is decorrelated
			crossover_pseudo_random_timer <= {1'b0, crossover_pseudo_random_timer[15:1]}
				^ (crossover_pseudo_random_timer[0] ? crossover_pseudo_random_timer_taps : 16'h0000);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			interval_count <= 32'h0000_0000;
			interval_target <= 32'(xover_min_cycles);
			mdix_select <= 1'b0;
		end else if (!auto_xover) begin
			interval_count <= 32'h0000_0000;
			mdix_select <= mode_ctl.xover_manual;
		end else if (signal_seen || state == pm_down) begin
			interval_count <= 32'h0000_0000;
		end else if (interval_count + 32'h0000_0001 >= interval_target) begin
			interval_count <= 32'h0000_0000;
			interval_target <= pick_interval(crossover_pseudo_random_timer);
			mdix_select <= ~mdix_select;
		end else begin
			interval_count <= interval_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			xover_status <= 1'b0;
		end else begin
			xover_status <= mdix_select;
		end
	end
endmodule

//--- pkg/phy_pwr_pkg.sv
package phy_pwr_pkg;
	localparam int clk_mhz = 200;
	// crossover switching interval limits, in milliseconds
	localparam int xover_min_ms = 200;
	localparam int xover_max_ms = 420;
	localparam longint xover_min_cycles = longint'(xover_min_ms) * 1000 * clk_mhz * 1000 / 1000;
	localparam longint xover_max_cycles = longint'(xover_max_ms) * 1000 * clk_mhz * 1000 / 1000;
	localparam int max_phys_on_bus = 32;
	localparam logic [15:0] crossover_pseudo_random_timer_seed = 16'hace1;
	localparam logic [15:0] crossover_pseudo_random_timer_taps = 16'hb400;
	// field positions of the bits that the control ports carry
	localparam int ctl_power_down_bit = 11;
	localparam int cfg_auto_reduced_bit = 4;
	localparam int spec_xover_disable_bit = 4;
	localparam int spec_xover_manual_bit = 5;
	localparam int spec_xover_status_bit = 7;
	localparam logic reset_auto_reduced = 1'b1;
	localparam logic reset_xover_disable = 1'b0;

	typedef enum logic [2:0] {
		pm_normal = 3'b001,
		pm_reduced = 3'b010,
		pm_down = 3'b100
	} power_state_t;

	typedef struct packed {
		logic power_down;
		logic auto_reduced_en;
		logic xover_disable;
		logic xover_manual;
	} mode_ctl_t;

	typedef struct packed {
		logic fast_link_pulse;
		logic normal_link_pulse;
		logic mlt3_signal;
		logic cable_present;
	} media_sense_t;
endpackage

//--- verif/link_partner.sv
`timescale 1ns/1ps
module link_partner
	import phy_pwr_pkg::*;
(
	input wire logic plugged,
	input wire logic [1:0] kind,
	output media_sense_t media
);
	// an unplugged cable carries no pulses of any kind
	assign media = {plugged && kind == 2'h1, plugged && kind == 2'h2,
		plugged && kind == 2'h3, plugged};
endmodule

//--- verif/phy_power_and_mdix_control_tb_top.sv
`timescale 1ns/1ps
module phy_power_and_mdix_control_tb_top;
	import phy_pwr_pkg::*;
	logic clk = 0, nrst = 0, pin = 0, strap = 0, plug = 1;
	logic [1:0] kind = 2'h0;
	mode_ctl_t ctl = 4'h4;
	media_sense_t media;
	logic sde, txe, rxe, miie, mge, flp, red, fpd, mdix, xst;
	logic maddr = 0, mbit = 0, mval = 0, mo, moe;
	int miscompares = 0, n_compared = 0;
	always #2.5 clk = ~clk;
	link_partner u_lp(.plugged(plug), .kind(kind), .media(media));
	phy_power_mdix u_dut(.clk(clk), .nrst(nrst), .power_down_pin(pin), .xover_strap(strap),
		.mode_ctl(ctl), .media(media), .mdio_addressed(maddr), .mdio_out_bit(mbit),
		.mdio_out_valid(mval), .mdio_o(mo), .mdio_oe(moe), .signal_detect_en(sde), .tx_enable(txe),
		.rx_enable(rxe), .mii_enable(miie), .mgmt_enable(mge), .tx_flp_low_power(flp),
		.reduced_power(red), .full_power_down(fpd), .mdix_select(mdix), .xover_status(xst));
	task chk(input logic s, input logic e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t mismatch", $time);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task finish_test;
		$display("compared %0d bad %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// unplug, then wake by each of the three signal kinds
	task t_reduced;
		for (int k = 1; k < 4; k++) begin
			@(posedge clk) plug <= 1'b0;
			step(2);
			chk(red, 1'b1);
			chk(flp & ~rxe & sde, 1'b1);
			@(posedge clk) {plug, kind} <= {1'b1, 2'(k)};
			step(2);
			chk(red | ~rxe, 1'b0);
		end
		$display("t_reduced done");
	endtask
	task t_noauto;
		@(posedge clk) {ctl.auto_reduced_en, plug, kind} <= 4'h0;
		step(4);
		chk(red, 1'b0);
		@(posedge clk) {ctl.auto_reduced_en, plug} <= 2'h3;
		$display("t_noauto done");
	endtask
	// pin and register bit must each force power down alone
	task t_down;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk) {pin, ctl.power_down} <= 2'(s + 1);
			step(2);
			chk(fpd & mge & sde, 1'b1);
			chk(txe | rxe | miie, 1'b0);
			@(posedge clk) {pin, ctl.power_down} <= 2'h0;
			step(2);
			chk(fpd | ~txe, 1'b0);
		end
		$display("t_down done");
	endtask
	// strap high, then register disable, each with both manual values
	task t_manual;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {strap, ctl.xover_disable, ctl.xover_manual} <= {~i[1], i[1], i[0]};
			step(3);
			chk(mdix, i[0]);
			chk(xst, i[0]);
		end
		$display("t_manual done");
	endtask
	// the pin may only be driven while this device is the one addressed
	task t_mdio;
		@(posedge clk) {maddr, mval, mbit} <= 3'h7;
		step(1);
		chk(moe & mo, 1'b1);
		@(posedge clk) maddr <= 1'b0;
		step(1);
		chk(moe, 1'b0);
		@(posedge clk) {maddr, mval, mbit} <= 3'h4;
		step(1);
		chk(moe, 1'b0);
		@(posedge clk) maddr <= 1'b0;
		$display("t_mdio done");
	endtask
	initial begin
		step(10);
		chk(txe | mdix, 1'b0);
		@(posedge clk) nrst <= 1'b1;
		step(2);
		chk(txe, 1'b1);
		t_reduced();
		t_noauto();
		t_down();
		t_manual();
		t_mdio();
		finish_test();
	end
	// the tests need well under a thousand cycles
	initial begin
		#20us;
		miscompares++;
		finish_test();
	end
endmodule

//--- verif/phy_power_mdix_properties.sv
`timescale 1ns/1ps
module phy_power_mdix_chk
	import phy_pwr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic power_down_pin,
	input wire logic xover_strap,
	input wire mode_ctl_t mode_ctl,
	input wire media_sense_t media,
	input wire logic mdio_addressed,
	input wire logic mdio_out_valid,
	input wire logic mdio_out_bit,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic signal_detect_en,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic mii_enable,
	input wire logic mgmt_enable,
	input wire logic tx_flp_low_power,
	input wire logic reduced_power,
	input wire logic full_power_down,
	input wire logic mdix_select,
	input wire logic xover_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire sig = media.fast_link_pulse | media.normal_link_pulse | media.mlt3_signal;
	wire pd = power_down_pin | mode_ctl.power_down;
	monitor_on_a: assert property (signal_detect_en && mgmt_enable)
		else $error("monitor or management off");
	reduced_in_a: assert property (!media.cable_present && !sig && mode_ctl.auto_reduced_en
		&& !pd && !full_power_down |=> reduced_power) else $error("no reduced entry");
	reduced_flp_a: assert property (reduced_power |-> tx_flp_low_power && !rx_enable)
		else $error("reduced without low power pulses");
	wake_up_a: assert property (reduced_power && sig && !pd |=> !reduced_power)
		else $error("no wake on signal");
	no_auto_a: assert property (!mode_ctl.auto_reduced_en |=> !reduced_power)
		else $error("reduced while disabled");
	down_in_a: assert property (pd |=> full_power_down)
		else $error("no power down");
	down_off_a: assert property (full_power_down |-> !tx_enable && !rx_enable && !mii_enable)
		else $error("data path on in power down");
	manual_sel_a: assert property (xover_strap || mode_ctl.xover_disable
		|=> mdix_select == $past(mode_ctl.xover_manual)) else $error("manual select wrong");
	status_copy_a: assert property (1'b1 |=> xover_status == $past(mdix_select))
		else $error("status not tracking select");
	hold_sel_a: assert property (!xover_strap && !mode_ctl.xover_disable && sig
		|=> $stable(mdix_select)) else $error("crossover toggled with signal present");
	mdio_drive_a: assert property (1'b1 |=> mdio_oe == $past(mdio_addressed && mdio_out_valid))
		else $error("management pin driven when not addressed");
	mdio_data_a: assert property (mdio_addressed && mdio_out_valid |=> mdio_o == $past(mdio_out_bit))
		else $error("management pin data wrong");
	cover property ($rose(reduced_power));
	cover property ($rose(full_power_down));
	cover property ($rose(mdix_select));
endmodule
bind phy_power_mdix phy_power_mdix_chk u_chk(.*);
